/* File: rtl/lmpc_codec.sv */
// Overview of operation
// - Master polls slave within maximum poll interval
// - Link procedures allowed before host connection
// - Host wish sends host connection request
// - Received connection request notifies local host
// - Send setup complete, keep answering requests
// - Other traffic waits for both setup completes
// - Accepted: 2 bytes, opcode 3, echoed opcode
// - Not accepted: 3 bytes, opcode, reason
// - Host connection request: 1 byte, opcode 51
// - Random PDUs: 17 bytes, DM1 only
// - Clock offset request and response coding
// - Feature request/response: 9 bytes, mask
// - Power request and indication PDU coding
// - Encryption mode and key size: 2 bytes
// - Automatic rate: 1 byte, opcode 35
// - Max slot PDUs: 2 bytes, directions fixed
// - Name request/response coding, response DM1 only
// - Beacon modification: 11 or 13 bytes, DM1
// - Page and page scan mode: 3 bytes
// - Setup complete: 1 byte, opcode 49, DM1
`timescale 1ns/1ps
`default_nettype none

module lmpc_codec #(
	parameter int POLL_MAX_CYC = lmpc_pkg::POLL_MAX_CYC
) (
	input  wire logic                  clk,            // 10 MHz clock
	input  wire logic                  rst_n,          // Sync reset, active low
	input  wire logic                  is_master,      // Local role is master
	input  wire logic                  page_done,      // Paging finished, pulse
	input  wire logic                  tx_any_pkt,     // Baseband sent a packet, pulse
	output logic                       poll_req,       // Send POLL/NULL now, pulse
	input  wire logic                  host_conn_req,  // Host wants connection, pulse
	output logic                       host_conn_ind,  // Incoming connection, pulse
	input  wire logic                  host_accept,    // Host accepts incoming, pulse
	input  wire logic                  host_reject,    // Host rejects incoming, pulse
	input  wire logic [7:0]            host_reason,    // Reject reason code
	output logic                       conn_accepted,  // Peer accepted ours, pulse
	output logic                       conn_rejected,  // Peer rejected ours, pulse
	output logic [7:0]                 conn_reason,    // Peer reject reason
	input  wire logic                  lm_setup_done,  // Local set-up finished, pulse
	output logic                       local_sc_sent,  // Our setup complete sent
	output logic                       peer_sc_rcvd,   // Peer setup complete seen
	output logic                       traffic_en,     // Other channels may send
	input  wire logic                  usr_tx_valid,   // User PDU offered
	input  wire lmpc_pkg::lmpc_pdu_type usr_tx_pdu,    // User PDU
	output logic                       usr_tx_ready,   // User PDU taken
	output logic                       usr_tx_err,     // User PDU refused, pulse
	output logic                       tx_valid,       // Payload byte valid
	output logic [7:0]                 tx_byte,        // Payload byte
	output logic                       tx_last,        // Last byte of PDU
	output logic                       tx_dm1_only,    // PDU must go in DM1
	input  wire logic                  tx_ready,       // Baseband takes byte
	input  wire logic                  rx_valid,       // Received byte valid
	input  wire logic [7:0]            rx_byte,        // Received byte
	input  wire logic                  rx_last,        // Last received byte
	input  wire logic                  rx_is_dv,       // Arrived in a DV packet
	output logic                       rx_pdu_valid,   // Good PDU, pulse
	output lmpc_pkg::lmpc_pdu_type     rx_pdu,         // Received PDU
	output logic                       rx_err          // Bad PDU dropped, pulse
);

	localparam int PW = $clog2(POLL_MAX_CYC + 1);
	localparam logic [PW-1:0] POLL_LAST = PW'(POLL_MAX_CYC - 1);

	// Session state
	logic linked_r, linked_nxt;
	logic local_sc_r, local_sc_nxt;
	logic peer_sc_r, peer_sc_nxt;
	logic traffic_r, traffic_nxt;

	// Poll supervision
	logic [PW-1:0] poll_cnt_r, poll_cnt_nxt;
	logic          poll_r, poll_nxt;

	// Transmit framer
	lmpc_pkg::lmpc_tx_state_type tx_st_r, tx_st_nxt;
	lmpc_pkg::lmpc_pdu_type      tx_pdu_r, tx_pdu_nxt;
	logic [4:0]                  tx_idx_r, tx_idx_nxt;
	logic                        pend_hcr_r, pend_hcr_nxt;
	logic                        pend_acc_r, pend_acc_nxt;
	logic                        pend_nacc_r, pend_nacc_nxt;
	logic                        pend_sc_r, pend_sc_nxt;
	logic [7:0]                  nacc_rsn_r, nacc_rsn_nxt;
	logic                        uerr_r, uerr_nxt;
	logic                        tx_done;

	// Receive deframer
	lmpc_pkg::lmpc_pdu_type rx_acc_r, rx_acc_nxt;
	lmpc_pkg::lmpc_pdu_type rx_cur;
	lmpc_pkg::lmpc_pdu_type rx_pdu_r, rx_pdu_nxt;
	logic [4:0]             rx_cnt_r, rx_cnt_nxt;
	logic                   rx_ovf_r, rx_ovf_nxt;
	logic                   rx_vld_r, rx_vld_nxt;
	logic                   rx_err_r, rx_err_nxt;
	logic                   hind_r, hind_nxt;
	logic                   cacc_r, cacc_nxt;
	logic                   crej_r, crej_nxt;
	logic [7:0]             crsn_r, crsn_nxt;
	logic                   rx_good;
	logic [4:0]             rx_total;

	// Poll gap counter; restarts on any packet sent to the slave
	always_comb begin
		poll_cnt_nxt = poll_cnt_r;
		poll_nxt     = 1'b0;
		if (!(is_master && linked_r) || tx_any_pkt) begin
			poll_cnt_nxt = '0;
		end else if (poll_cnt_r == POLL_LAST) begin
			poll_cnt_nxt = '0;
			poll_nxt     = 1'b1;
		end else begin
			poll_cnt_nxt = poll_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			poll_cnt_r <= '0;
			poll_r     <= 1'b0;
		end else begin
			poll_cnt_r <= poll_cnt_nxt;
			poll_r     <= poll_nxt;
		end
	end

	assign tx_done = (tx_st_r == lmpc_pkg::TX_SEND) && tx_ready && (tx_idx_r == tx_pdu_r.len - 5'h01);

	// Transmit: internal PDUs go ahead of user PDUs
	always_comb begin
		tx_st_nxt     = tx_st_r;
		tx_pdu_nxt    = tx_pdu_r;
		tx_idx_nxt    = tx_idx_r;
		uerr_nxt      = 1'b0;
		nacc_rsn_nxt  = host_reject ? host_reason : nacc_rsn_r;
		pend_hcr_nxt  = pend_hcr_r | (host_conn_req & linked_r);
		pend_acc_nxt  = pend_acc_r | host_accept;
		pend_nacc_nxt = pend_nacc_r | host_reject;
		pend_sc_nxt   = pend_sc_r | (lm_setup_done & linked_r & ~local_sc_r);
		usr_tx_ready  = (tx_st_r == lmpc_pkg::TX_IDLE) && linked_r &&
			!(pend_hcr_r || pend_acc_r || pend_nacc_r || pend_sc_r);
		unique case (tx_st_r)
			lmpc_pkg::TX_IDLE: begin
				tx_idx_nxt = lmpc_pkg::POS_OPCODE;
				tx_pdu_nxt = '0;
				if (pend_acc_r) begin
					tx_pdu_nxt.opcode = lmpc_pkg::OP_ACCEPTED;
					tx_pdu_nxt.len    = lmpc_pkg::LEN_2;
					tx_pdu_nxt.param[lmpc_pkg::PAR_OPCODE] = lmpc_pkg::OP_HOST_CONN;
					pend_acc_nxt      = host_accept;
					tx_st_nxt         = lmpc_pkg::TX_SEND;
				end else if (pend_nacc_r) begin
					tx_pdu_nxt.opcode = lmpc_pkg::OP_NOT_ACC;
					tx_pdu_nxt.len    = lmpc_pkg::LEN_3;
					tx_pdu_nxt.param[lmpc_pkg::PAR_OPCODE] = lmpc_pkg::OP_HOST_CONN;
					tx_pdu_nxt.param[lmpc_pkg::PAR_REASON] = nacc_rsn_r;
					pend_nacc_nxt     = host_reject;
					tx_st_nxt         = lmpc_pkg::TX_SEND;
				end else if (pend_hcr_r) begin
					tx_pdu_nxt.opcode = lmpc_pkg::OP_HOST_CONN;
					tx_pdu_nxt.len    = lmpc_pkg::LEN_1;
					pend_hcr_nxt      = host_conn_req & linked_r;
					tx_st_nxt         = lmpc_pkg::TX_SEND;
				end else if (pend_sc_r) begin
					tx_pdu_nxt.opcode = lmpc_pkg::OP_SETUP_DONE;
					tx_pdu_nxt.len    = lmpc_pkg::LEN_1;
					pend_sc_nxt       = 1'b0;
					tx_st_nxt         = lmpc_pkg::TX_SEND;
				end else if (usr_tx_valid && usr_tx_ready) begin
					if (lmpc_pkg::lmpc_len_ok(usr_tx_pdu.opcode, usr_tx_pdu.len) &&
						lmpc_pkg::lmpc_dir_ok(usr_tx_pdu.opcode, is_master)) begin
						tx_pdu_nxt = usr_tx_pdu;
						tx_st_nxt  = lmpc_pkg::TX_SEND;
					end else begin
						uerr_nxt = 1'b1;
					end
				end
			end
			lmpc_pkg::TX_SEND: begin
				if (tx_done) begin
					tx_st_nxt = lmpc_pkg::TX_IDLE;
				end else if (tx_ready) begin
					tx_idx_nxt = tx_idx_r + 5'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_st_r     <= lmpc_pkg::TX_IDLE;
			tx_pdu_r    <= '0;
			tx_idx_r    <= '0;
			pend_hcr_r  <= 1'b0;
			pend_acc_r  <= 1'b0;
			pend_nacc_r <= 1'b0;
			pend_sc_r   <= 1'b0;
			nacc_rsn_r  <= '0;
			uerr_r      <= 1'b0;
		end else begin
			tx_st_r     <= tx_st_nxt;
			tx_pdu_r    <= tx_pdu_nxt;
			tx_idx_r    <= tx_idx_nxt;
			pend_hcr_r  <= pend_hcr_nxt;
			pend_acc_r  <= pend_acc_nxt;
			pend_nacc_r <= pend_nacc_nxt;
			pend_sc_r   <= pend_sc_nxt;
			nacc_rsn_r  <= nacc_rsn_nxt;
			uerr_r      <= uerr_nxt;
		end
	end

	// Opcode in byte 1, parameters from byte 2 on
	always_comb begin
		tx_byte = tx_pdu_r.opcode;
		if (tx_idx_r >= lmpc_pkg::POS_PARAM) begin
			tx_byte = tx_pdu_r.param[4'(tx_idx_r - lmpc_pkg::POS_PARAM)];
		end
	end

	assign tx_valid    = (tx_st_r == lmpc_pkg::TX_SEND);
	assign tx_last     = tx_valid && (tx_idx_r == tx_pdu_r.len - 5'h01);
	assign tx_dm1_only = tx_valid && lmpc_pkg::lmpc_dm1_only(tx_pdu_r.opcode);

	// Receive: current byte merged into the accumulator
	always_comb begin
		rx_cur = rx_acc_r;
		if (rx_cnt_r == lmpc_pkg::POS_OPCODE) begin
			rx_cur.opcode = rx_byte;
		end else if (rx_cnt_r < lmpc_pkg::LEN_MAX) begin
			rx_cur.param[4'(rx_cnt_r - lmpc_pkg::POS_PARAM)] = rx_byte;
		end
		rx_total   = rx_cnt_r + 5'h01;
		rx_cur.len = rx_total;
	end

	// Length tied to opcode; DM1-only PDUs refused from DV packets
	assign rx_good = !rx_ovf_r && (rx_cnt_r < lmpc_pkg::LEN_MAX) &&
		lmpc_pkg::lmpc_len_ok(rx_cur.opcode, rx_total) &&
		lmpc_pkg::lmpc_dir_ok(rx_cur.opcode, !is_master) &&
		!(rx_is_dv && lmpc_pkg::lmpc_dm1_only(rx_cur.opcode));

	always_comb begin
		rx_acc_nxt = rx_acc_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_ovf_nxt = rx_ovf_r;
		rx_pdu_nxt = rx_pdu_r;
		rx_vld_nxt = 1'b0;
		rx_err_nxt = 1'b0;
		hind_nxt   = 1'b0;
		cacc_nxt   = 1'b0;
		crej_nxt   = 1'b0;
		crsn_nxt   = crsn_r;
		if (rx_valid) begin
			rx_acc_nxt = rx_cur;
			if (rx_cnt_r < lmpc_pkg::LEN_MAX) begin
				rx_cnt_nxt = rx_total;
			end else begin
				rx_ovf_nxt = 1'b1;
			end
			if (rx_last) begin
				rx_cnt_nxt = '0;
				rx_ovf_nxt = 1'b0;
				rx_acc_nxt = '0;
				if (rx_good) begin
					rx_pdu_nxt = rx_cur;
					rx_vld_nxt = 1'b1;
					hind_nxt   = (rx_cur.opcode == lmpc_pkg::OP_HOST_CONN);
					if (rx_cur.param[lmpc_pkg::PAR_OPCODE] == lmpc_pkg::OP_HOST_CONN) begin
						cacc_nxt = (rx_cur.opcode == lmpc_pkg::OP_ACCEPTED);
						crej_nxt = (rx_cur.opcode == lmpc_pkg::OP_NOT_ACC);
						if (rx_cur.opcode == lmpc_pkg::OP_NOT_ACC) begin
							crsn_nxt = rx_cur.param[lmpc_pkg::PAR_REASON];
						end
					end
				end else begin
					rx_err_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_acc_r <= '0;
			rx_cnt_r <= '0;
			rx_ovf_r <= 1'b0;
			rx_pdu_r <= '0;
			rx_vld_r <= 1'b0;
			rx_err_r <= 1'b0;
			hind_r   <= 1'b0;
			cacc_r   <= 1'b0;
			crej_r   <= 1'b0;
			crsn_r   <= '0;
		end else begin
			rx_acc_r <= rx_acc_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_ovf_r <= rx_ovf_nxt;
			rx_pdu_r <= rx_pdu_nxt;
			rx_vld_r <= rx_vld_nxt;
			rx_err_r <= rx_err_nxt;
			hind_r   <= hind_nxt;
			cacc_r   <= cacc_nxt;
			crej_r   <= crej_nxt;
			crsn_r   <= crsn_nxt;
		end
	end

	// Session: link up after paging, traffic once both completes exchanged
	always_comb begin
		linked_nxt   = linked_r | page_done;
		local_sc_nxt = local_sc_r |
			(tx_done && (tx_pdu_r.opcode == lmpc_pkg::OP_SETUP_DONE));
		peer_sc_nxt  = peer_sc_r | (rx_valid && rx_last && rx_good &&
			(rx_cur.opcode == lmpc_pkg::OP_SETUP_DONE));
		traffic_nxt  = local_sc_r && peer_sc_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			linked_r   <= 1'b0;
			local_sc_r <= 1'b0;
			peer_sc_r  <= 1'b0;
			traffic_r  <= 1'b0;
		end else begin
			linked_r   <= linked_nxt;
			local_sc_r <= local_sc_nxt;
			peer_sc_r  <= peer_sc_nxt;
			traffic_r  <= traffic_nxt;
		end
	end

	assign poll_req      = poll_r;
	assign host_conn_ind = hind_r;
	assign conn_accepted = cacc_r;
	assign conn_rejected = crej_r;
	assign conn_reason   = crsn_r;
	assign local_sc_sent = local_sc_r;
	assign peer_sc_rcvd  = peer_sc_r;
	assign traffic_en    = traffic_r;
	assign usr_tx_err    = uerr_r;
	assign rx_pdu_valid  = rx_vld_r;
	assign rx_pdu        = rx_pdu_r;
	assign rx_err        = rx_err_r;

endmodule

`default_nettype wire

/* File: rtl/lmpc_pkg.sv */
package lmpc_pkg;

	// Opcodes carried in payload byte 1
	localparam logic [7:0] OP_NAME_REQ     = 8'h01;
	localparam logic [7:0] OP_NAME_RES     = 8'h02;
	localparam logic [7:0] OP_ACCEPTED     = 8'h03;
	localparam logic [7:0] OP_NOT_ACC      = 8'h04;
	localparam logic [7:0] OP_CLKOFF_REQ   = 8'h05;
	localparam logic [7:0] OP_CLKOFF_RES   = 8'h06;
	localparam logic [7:0] OP_DETACH       = 8'h07;
	localparam logic [7:0] OP_IN_RAND      = 8'h08;
	localparam logic [7:0] OP_COMB_KEY     = 8'h09;
	localparam logic [7:0] OP_AU_RAND      = 8'h0b;
	localparam logic [7:0] OP_ENC_MODE     = 8'h0f;
	localparam logic [7:0] OP_KEY_SIZE     = 8'h10;
	localparam logic [7:0] OP_HOLD         = 8'h14;
	localparam logic [7:0] OP_HOLD_REQ     = 8'h15;
	localparam logic [7:0] OP_MOD_BEACON   = 8'h1c;
	localparam logic [7:0] OP_INCR_PWR     = 8'h1f;
	localparam logic [7:0] OP_DECR_PWR     = 8'h20;
	localparam logic [7:0] OP_MAX_PWR      = 8'h21;
	localparam logic [7:0] OP_MIN_PWR      = 8'h22;
	localparam logic [7:0] OP_AUTO_RATE    = 8'h23;
	localparam logic [7:0] OP_FEAT_REQ     = 8'h27;
	localparam logic [7:0] OP_FEAT_RES     = 8'h28;
	localparam logic [7:0] OP_MAX_SLOT     = 8'h2d;
	localparam logic [7:0] OP_MAX_SLOT_REQ = 8'h2e;
	localparam logic [7:0] OP_SETUP_DONE   = 8'h31;
	localparam logic [7:0] OP_HOST_CONN    = 8'h33;
	localparam logic [7:0] OP_PAGE_MODE    = 8'h35;
	localparam logic [7:0] OP_PSCAN_MODE   = 8'h36;

	// PDU lengths in bytes, opcode byte included
	localparam logic [4:0] LEN_1   = 5'h01;
	localparam logic [4:0] LEN_2   = 5'h02;
	localparam logic [4:0] LEN_3   = 5'h03;
	localparam logic [4:0] LEN_9   = 5'h09;
	localparam logic [4:0] LEN_11  = 5'h0b;
	localparam logic [4:0] LEN_13  = 5'h0d;
	localparam logic [4:0] LEN_MAX = 5'h11;

	// Byte positions (0 = opcode byte, param index 0 = payload byte 2)
	localparam logic [4:0] POS_OPCODE = 5'h00;
	localparam logic [4:0] POS_PARAM  = 5'h01;
	localparam logic [3:0] PAR_OPCODE = 4'h0;
	localparam logic [3:0] PAR_REASON = 4'h1;

	// Poll supervision: slot time and longest poll gap, rounded down
	localparam int CLK_NS         = 100;
	localparam int SLOT_NS        = 625000;
	localparam int POLL_MAX_SLOTS = 40;
	localparam int POLL_MAX_CYC   = POLL_MAX_SLOTS * SLOT_NS / CLK_NS;

	typedef struct packed {
		logic [7:0]       opcode;
		logic [4:0]       len;
		logic [15:0][7:0] param;
	} lmpc_pdu_type;

	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} lmpc_tx_state_type;

	function automatic logic lmpc_len_ok(input logic [7:0] op, input logic [4:0] len);
		case (op)
			OP_HOST_CONN, OP_SETUP_DONE, OP_CLKOFF_REQ, OP_AUTO_RATE,
			OP_MAX_PWR, OP_MIN_PWR:
				return len == LEN_1;
			OP_ACCEPTED, OP_DETACH, OP_INCR_PWR, OP_DECR_PWR, OP_ENC_MODE,
			OP_KEY_SIZE, OP_MAX_SLOT, OP_MAX_SLOT_REQ, OP_NAME_REQ:
				return len == LEN_2;
			OP_NOT_ACC, OP_CLKOFF_RES, OP_HOLD, OP_HOLD_REQ, OP_PAGE_MODE,
			OP_PSCAN_MODE:
				return len == LEN_3;
			OP_FEAT_REQ, OP_FEAT_RES:
				return len == LEN_9;
			OP_AU_RAND, OP_IN_RAND, OP_COMB_KEY, OP_NAME_RES:
				return len == LEN_MAX;
			OP_MOD_BEACON:
				return (len == LEN_11) || (len == LEN_13);
			default:
				return (len >= LEN_1) && (len <= LEN_MAX);
		endcase
	endfunction

	function automatic logic lmpc_dm1_only(input logic [7:0] op);
		return (op == OP_AU_RAND) || (op == OP_IN_RAND) || (op == OP_COMB_KEY) ||
			(op == OP_NAME_RES) || (op == OP_MOD_BEACON) || (op == OP_SETUP_DONE);
	endfunction

	// from_master: sender of the PDU is the master
	function automatic logic lmpc_dir_ok(input logic [7:0] op, input logic from_master);
		case (op)
			OP_CLKOFF_REQ, OP_MAX_SLOT, OP_MOD_BEACON:
				return from_master;
			OP_CLKOFF_RES, OP_MAX_SLOT_REQ:
				return !from_master;
			default:
				return 1'b1;
		endcase
	endfunction

endpackage

/* File: tb/lmpc_codec_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module lmpc_codec_asserts #(
	parameter int POLL_MAX_CYC = 20
) (
	input wire logic       clk,           // Clock
	input wire logic       rst_n,         // Reset
	input wire logic       is_master,     // Role
	input wire logic       page_done,     // Linked
	input wire logic       tx_any_pkt,    // Packet sent
	input wire logic       poll_req,      // Poll
	input wire logic       host_conn_ind, // Incoming
	input wire logic       conn_accepted, // Accepted
	input wire logic       local_sc_sent, // Ours sent
	input wire logic       peer_sc_rcvd,  // Theirs seen
	input wire logic       traffic_en,    // Open
	input wire logic       usr_tx_valid,  // Offer
	input wire logic       usr_tx_ready,  // Taken
	input wire logic       usr_tx_err,    // Refused
	input wire logic       tx_valid,      // Tx valid
	input wire logic [7:0] tx_byte,       // Tx byte
	input wire logic       tx_last,       // Tx last
	input wire logic       tx_ready,      // Tx taken
	input wire logic       rx_valid,      // Rx valid
	input wire logic [7:0] rx_byte,       // Rx byte
	input wire logic       rx_last,       // Rx last
	input wire logic       rx_is_dv,      // Rx in DV
	input wire logic       rx_pdu_valid,  // Rx good
	input wire logic       rx_err         // Rx dropped
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic        link_r, link_nxt, first_r, first_nxt;
	logic [31:0] gap_r, gap_nxt;
	always_comb begin
		link_nxt = link_r | page_done;
		first_nxt = rx_valid ? rx_last : first_r;
		// Idle gap of a linked master
		gap_nxt = (is_master && link_r && !tx_any_pkt && !poll_req) ? gap_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link_r <= 1'b0;
			first_r <= 1'b1;
			gap_r <= 32'h0;
		end else begin
			link_r <= link_nxt;
			first_r <= first_nxt;
			gap_r <= gap_nxt;
		end
	end
	sequence s_rx_one(logic [7:0] op);
		link_r && rx_valid && first_r && rx_last && rx_byte == op;
	endsequence
	sequence s_rx_acc;
		link_r && rx_valid && first_r && !rx_last && rx_byte == 8'h03 ##1
		rx_valid && rx_last && rx_byte == 8'h33;
	endsequence
	a_poll_gap: assert property (gap_r <= POLL_MAX_CYC + 2)
		else $error("Poll gap too long");
	a_poll_role: assert property (poll_req |-> is_master && link_r)
		else $error("Poll when not linked master");
	a_conn_ind: assert property (s_rx_one(8'h33) |=> host_conn_ind && rx_pdu_valid)
		else $error("No incoming indication");
	a_conn_acc: assert property (s_rx_acc |=> conn_accepted)
		else $error("Accept not reported");
	a_len_short: assert property (s_rx_one(8'h03) |=> rx_err && !rx_pdu_valid)
		else $error("Short PDU not dropped");
	a_dv_refuse: assert property (s_rx_one(8'h31) ##0 rx_is_dv |=> rx_err)
		else $error("DM1-only PDU in DV taken");
	a_peer_sc: assert property (s_rx_one(8'h31) ##0 !rx_is_dv |=> peer_sc_rcvd)
		else $error("Peer setup complete missed");
	a_sc_sent: assert property ($rose(local_sc_sent) |-> $past(tx_last) &&
		$past(tx_valid) && $past(tx_ready) && $past(tx_byte) == 8'h31)
		else $error("Setup complete flag without send");
	a_traf_gate: assert property (traffic_en |-> local_sc_sent && peer_sc_rcvd)
		else $error("Traffic open too early");
	a_traf_open: assert property (local_sc_sent && peer_sc_rcvd |=> traffic_en)
		else $error("Traffic not opened");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_byte) && $stable(tx_last))
		else $error("Tx byte changed while stalled");
	a_usr_ans: assert property (usr_tx_valid && usr_tx_ready |=> tx_valid != usr_tx_err)
		else $error("User PDU not answered");
endmodule
bind lmpc_codec lmpc_codec_asserts #(.POLL_MAX_CYC(POLL_MAX_CYC)) chk_u (
	.clk(clk), .rst_n(rst_n), .is_master(is_master), .page_done(page_done),
	.tx_any_pkt(tx_any_pkt), .poll_req(poll_req), .host_conn_ind(host_conn_ind),
	.conn_accepted(conn_accepted), .local_sc_sent(local_sc_sent),
	.peer_sc_rcvd(peer_sc_rcvd), .traffic_en(traffic_en), .usr_tx_valid(usr_tx_valid),
	.usr_tx_ready(usr_tx_ready), .usr_tx_err(usr_tx_err), .tx_valid(tx_valid),
	.tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
	.rx_byte(rx_byte), .rx_last(rx_last), .rx_is_dv(rx_is_dv),
	.rx_pdu_valid(rx_pdu_valid), .rx_err(rx_err)
);
`default_nettype wire

/* File: tb/lmpc_codec_test.sv */
`timescale 1ns/1ps
`default_nettype none
module lmpc_codec_test;
	localparam int POLL_CYC = 20;
	logic clk = 1'b0, rst_n = 1'b0, is_master = 1'b1, slow = 1'b0;
	logic page_done = 1'b0, tx_any_pkt = 1'b0, host_conn_req = 1'b0;
	logic host_accept = 1'b0, host_reject = 1'b0, lm_setup_done = 1'b0, usr_tx_valid = 1'b0;
	logic [7:0] host_reason = 8'h00;
	lmpc_pkg::lmpc_pdu_type usr_tx_pdu = '0;
	logic poll_req, host_conn_ind, conn_accepted, conn_rejected, local_sc_sent, peer_sc_rcvd;
	logic traffic_en, usr_tx_ready, usr_tx_err, tx_valid, tx_last, tx_dm1_only, tx_ready;
	logic rx_valid, rx_last, rx_is_dv, rx_pdu_valid, rx_err;
	logic [7:0] conn_reason, tx_byte, rx_byte;
	lmpc_pkg::lmpc_pdu_type rx_pdu, e, p;
	logic [31:0] seed = 32'h1d49;
	int bad_count = 0, checked = 0, cyc = 0;
	int n_ind, n_acc, n_rej, n_poll, n_uerr, x_uerr;
	logic [9:0] txq[$];
	lmpc_pkg::lmpc_pdu_type rxq[$];
	// {opcode, dm1, slave-only, master-only, len}
	logic [15:0] tbl[24] = '{16'h0102, 16'h0291, 16'h0521, 16'h0643, 16'h0702, 16'h0891,
		16'h0991, 16'h0b91, 16'h0f02, 16'h1002, 16'h1403, 16'h1503, 16'h1cad, 16'h1f02,
		16'h2002, 16'h2101, 16'h2201, 16'h2301, 16'h2709, 16'h2809, 16'h2d22, 16'h2e42,
		16'h3503, 16'h3603};

	always #50 clk = ~clk;

	lmpc_codec #(.POLL_MAX_CYC(POLL_CYC)) dut_u (.clk(clk), .rst_n(rst_n),
		.is_master(is_master), .page_done(page_done), .tx_any_pkt(tx_any_pkt),
		.poll_req(poll_req), .host_conn_req(host_conn_req), .host_conn_ind(host_conn_ind),
		.host_accept(host_accept), .host_reject(host_reject), .host_reason(host_reason),
		.conn_accepted(conn_accepted), .conn_rejected(conn_rejected),
		.conn_reason(conn_reason), .lm_setup_done(lm_setup_done),
		.local_sc_sent(local_sc_sent), .peer_sc_rcvd(peer_sc_rcvd), .traffic_en(traffic_en),
		.usr_tx_valid(usr_tx_valid), .usr_tx_pdu(usr_tx_pdu), .usr_tx_ready(usr_tx_ready),
		.usr_tx_err(usr_tx_err), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
		.tx_dm1_only(tx_dm1_only), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_last(rx_last), .rx_is_dv(rx_is_dv),
		.rx_pdu_valid(rx_pdu_valid), .rx_pdu(rx_pdu), .rx_err(rx_err));
	lmpc_peer peer_u (.clk(clk), .slow(slow), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_last(rx_last), .rx_is_dv(rx_is_dv));

	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic lmpc_pkg::lmpc_pdu_type mk(input logic [7:0] op, input logic [4:0] len);
		lmpc_pkg::lmpc_pdu_type q;
		q.opcode = op;
		q.len = len;
		for (int k = 0; k < 16; k++) q.param[k] = 8'(xorshift());
		return q;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic expect_tx(input lmpc_pkg::lmpc_pdu_type q, input logic dm1);
		for (int k = 0; k < q.len; k++)
			txq.push_back({dm1, k == q.len - 1, (k == 0) ? q.opcode : q.param[k-1]});
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while ((txq.size() != 0 || rxq.size() != 0) && n < 400) begin
			@(negedge clk);
			n++;
		end
		repeat (3) @(negedge clk);
	endtask
	task automatic usr_send(input lmpc_pkg::lmpc_pdu_type q, input logic good, input logic dm1);
		int n;
		n = 0;
		@(negedge clk);
		while (usr_tx_ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		usr_tx_pdu = q;
		usr_tx_valid = 1'b1;
		slow = 1'(xorshift());
		if (good) expect_tx(q, dm1);
		else x_uerr++;
		@(negedge clk);
		usr_tx_valid = 1'b0;
		wait_idle();
	endtask
	task automatic peer_send(input lmpc_pkg::lmpc_pdu_type q, input logic dv, input logic good);
		rxq.push_back(good ? q : '0);
		peer_u.send(q, dv);
		wait_idle();
	endtask

	always @(negedge clk) tx_any_pkt <= (xorshift() & 32'h3f) == 32'h0;

	// Retires the oldest expectation per result
	always @(posedge clk) begin
		if (rst_n) begin
			n_ind += host_conn_ind;
			n_acc += conn_accepted;
			n_rej += conn_rejected;
			n_poll += poll_req;
			n_uerr += usr_tx_err;
			if (tx_valid && tx_ready) begin
				if (txq.size() == 0) check(32'h1, 32'h0);
				else check({tx_dm1_only, tx_last, tx_byte}, txq.pop_front());
			end
			if (rx_pdu_valid || rx_err) begin
				e = (rxq.size() != 0) ? rxq.pop_front() : '0;
				check({rx_err, rx_pdu_valid}, (e.len != 0) ? 2'b01 : 2'b10);
				if (e.len != 0) begin
					check({rx_pdu.opcode, 3'b000, rx_pdu.len}, {e.opcode, 3'b000, e.len});
					for (int k = 0; k < e.len - 1; k++) check(rx_pdu.param[k], e.param[k]);
				end
			end
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		logic [7:0] op;
		logic [4:0] len;
		logic dm1, dv, tx_ok, rx_ok;
		for (int r = 1; r >= 0; r--) begin
			@(negedge clk);
			rst_n = 1'b0;
			is_master = r[0];
			repeat (12) @(negedge clk);
			{n_ind, n_acc, n_rej, n_poll, n_uerr, x_uerr} = '0;
			rst_n = 1'b1;
			check({traffic_en, usr_tx_ready}, 2'b00);
			pulse(page_done);
			expect_tx(mk(8'h33, 5'd1), 1'b0);
			pulse(host_conn_req);
			wait_idle();
			p = mk(8'h03, 5'd2);
			p.param[0] = 8'h33;
			peer_send(p, 1'b1, 1'b1);
			peer_send(mk(8'h03, 5'd1), 1'b0, 1'b0);
			expect_tx(mk(8'h33, 5'd1), 1'b0);
			pulse(host_conn_req);
			wait_idle();
			p = mk(8'h04, 5'd3);
			p.param[0] = 8'h33;
			peer_send(p, 1'b0, 1'b1);
			check(conn_reason, p.param[1]);
			for (int h = 0; h < 3; h++) begin
				peer_send(mk(8'h33, 5'd1), 1'b1, 1'b1);
				host_reason = 8'(xorshift());
				p = mk(h == 1 ? 8'h04 : 8'h03, h == 1 ? 5'd3 : 5'd2);
				p.param[0] = 8'h33;
				p.param[1] = host_reason;
				expect_tx(p, 1'b0);
				if (h == 1) pulse(host_reject);
				else pulse(host_accept);
				wait_idle();
				if (h == 1) begin
					check(traffic_en, 1'b0);
					txq.push_back(10'h331);
					pulse(lm_setup_done);
					wait_idle();
					check(local_sc_sent, 1'b1);
				end
			end
			foreach (tbl[i]) begin
				op = tbl[i][15:8];
				len = tbl[i][4:0];
				dm1 = tbl[i][7];
				tx_ok = !(tbl[i][5] && !is_master) && !(tbl[i][6] && is_master);
				rx_ok = !(tbl[i][5] && is_master) && !(tbl[i][6] && !is_master);
				dv = 1'(xorshift());
				usr_send(mk(op, len), tx_ok, dm1);
				usr_send(mk(op, len == 5'd17 ? 5'd16 : len + 5'd1), 1'b0, dm1);
				peer_send(mk(op, len), dv, rx_ok && !(dm1 && dv));
				peer_send(mk(op, len == 5'd17 ? 5'd16 : len + 5'd1), dv, 1'b0);
			end
			check(traffic_en, 1'b0);
			peer_send(mk(8'h31, 5'd1), 1'b1, 1'b0);
			peer_send(mk(8'h31, 5'd1), 1'b0, 1'b1);
			check({peer_sc_rcvd, traffic_en}, 2'b11);
			check({8'(n_ind), 8'(n_acc), 8'(n_rej)}, 24'h030101);
			check(n_uerr, x_uerr);
			check(n_poll != 0, is_master);
			check(txq.size() + rxq.size(), 0);
		end
		results();
	end
endmodule
`default_nettype wire

/* File: tb/lmpc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module lmpc_peer (
	input  wire logic       clk,      // Clock
	input  wire logic       slow,     // Stall every other cycle
	output logic            tx_ready, // Byte taken
	output logic            rx_valid, // Byte to device
	output logic [7:0]      rx_byte,  // Byte
	output logic            rx_last,  // Last byte
	output logic            rx_is_dv  // DV packet
);
	logic ph;
	initial begin
		tx_ready = 1'b1;
		ph = 1'b0;
		forever begin
			@(negedge clk);
			ph = !ph;
			tx_ready = !slow || ph;
		end
	end
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_last = 1'b0;
		rx_is_dv = 1'b0;
	end
	// Answers and setup completes are sent whole, opcode first
	task automatic send(input lmpc_pkg::lmpc_pdu_type p, input logic dv);
		for (int k = 0; k < p.len; k++) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_byte = (k == 0) ? p.opcode : p.param[k-1];
			rx_last = (k == p.len - 1);
			rx_is_dv = dv;
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_last = 1'b0;
		// Released line must not look like the last byte
		rx_byte = ~rx_byte;
	endtask
endmodule
`default_nettype wire
